/* design/fpe_flash_map.vh */
// Register offsets, field positions, reset values and state codes
`ifndef FPE_FLASH_MAP_VH
`define FPE_FLASH_MAP_VH

`define FPE_ADDR_W          12
`define FPE_OFF_SER_TIMER   12'h000
`define FPE_OFF_MODE_CTRL   12'h004
`define FPE_OFF_SETUP_ERR   12'h008
`define FPE_OFF_ERASE_LO    12'h00c
`define FPE_OFF_ERASE_HI    12'h010
`define FPE_OFF_STATUS      12'h014

`define FPE_STC_GATE_BIT    3

`define FPE_MC_HW_ALLOW     7
`define FPE_MC_SW_ALLOW     6
`define FPE_MC_ERASE_CHECK  3
`define FPE_MC_PROG_CHECK   2
`define FPE_MC_ERASE        1
`define FPE_MC_PROG         0

`define FPE_SE_FAULT        7
`define FPE_SE_WIPE_PREP    1
`define FPE_SE_WRITE_PREP   0

`define FPE_EH_TOP_BLOCK    7

`define FPE_RST_SER_TIMER   8'h00
`define FPE_RST_MODE_CTRL   8'h80
`define FPE_RST_SETUP_ERR   8'h00
`define FPE_RST_ERASE       8'h00

`define FPE_ST_IDLE         8'h01
`define FPE_ST_WRITE_PREP   8'h02
`define FPE_ST_PROG         8'h04
`define FPE_ST_PROG_CHECK   8'h08
`define FPE_ST_WIPE_PREP    8'h10
`define FPE_ST_ERASE        8'h20
`define FPE_ST_ERASE_CHECK  8'h40
`define FPE_ST_FAULT        8'h80

`endif

/* design/fpe_mode_decode.v */
// Mode pin synchroniser, reset-time capture and operating mode decode
`timescale 1ns/1ns
module fpe_mode_decode (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire       mode_sel_hi,
	input  wire       mode_sel_lo,
	input  wire       boot_sel_2,
	input  wire       boot_sel_1,
	input  wire       boot_sel_0,
	output reg  [4:0] modeCode_r,
	output wire       bootMode,
	output wire       userProgMode,
	output wire       romEnable,
	output wire       normalMode
);

	reg [4:0] pinMeta_r;
	reg [4:0] pinSync_r;

	// Two stages before anything looks at the pins
	always @(posedge sys_clk) begin
		pinMeta_r <= {mode_sel_hi, mode_sel_lo, boot_sel_2, boot_sel_1, boot_sel_0};
		pinSync_r <= pinMeta_r;
	end

	// Mode is taken while reset is held and frozen after release
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			modeCode_r <= pinSync_r;
		end
	end

	assign bootMode     = (modeCode_r[4:3] == 2'b00) & (modeCode_r[2:0] == 3'b111);
	assign userProgMode = modeCode_r[4];
	assign romEnable    = (modeCode_r[4:3] != 2'b01);
	assign normalMode   = (modeCode_r[4:3] == 2'b11);

endmodule

/* design/fpe_flash_ctrl.v */
// Flash program/erase control registers, APB slave and flash state sequencer
//
// What this block does
// - Flash control and erase-select registers reachable only while the register gate bit is 1.
// - Mode control register returns to 0x80 on reset, standby and low-power modes.
// - Hardware write allow bit is read-only, reads 1, ignores writes.
// - Software write allow bit is read/write and permits programming and erasing.
// - With software write allow 0, setting check, run, prep and block bits fails.
// - Bits 5 and 4 of mode control read 0 and ignore writes.
// - Setting erase check with write allow enters erase-verify; clearing leaves it.
// - Setting program check with write allow enters program-verify; clearing leaves it.
// - Erase bit starts only with write allow and wipe prep set; clearing stops.
// - Program bit starts only with write allow and write prep set; clearing stops.
// - Setup and error register cleared on reset and hardware standby.
// - Prep bits forced 0 in low-power modes and when write allow clears.
// - Fault flag is read-only, set by a flash error, enters error protection.
// - Wipe prep set with write allow enters erase setup; set before erase.
// - Write prep set with write allow enters program setup; set before program.
// - Operating mode comes from mode and boot select pins captured during reset.
`timescale 1ns/1ns
`include "fpe_flash_map.vh"
module fpe_flash_ctrl (
	input  wire                   sys_clk,
	input  wire                   reset_n,
	input  wire [`FPE_ADDR_W-1:0] paddr,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [31:0]            pwdata,
	input  wire [3:0]             pstrb,
	output reg  [31:0]            prdata,
	output wire                   pready,
	output wire                   pslverr,
	input  wire                   hwStandby,
	input  wire                   swStandby,
	input  wire                   subActive,
	input  wire                   subSleep,
	input  wire                   watchMode,
	input  wire                   flashErrEvt,
	input  wire                   mode_sel_hi,
	input  wire                   mode_sel_lo,
	input  wire                   boot_sel_2,
	input  wire                   boot_sel_1,
	input  wire                   boot_sel_0,
	output reg  [7:0]             flashState_r,
	output reg                    progRun_r,
	output reg                    eraseRun_r,
	output reg                    progCheck_r,
	output reg                    eraseCheck_r,
	output reg                    writePrepOn_r,
	output reg                    wipePrepOn_r,
	output reg                    errorProtect_r,
	output reg  [15:0]            eraseSelect_r,
	output wire                   bootMode,
	output wire                   userProgMode,
	output wire                   romEnable
);

	localparam [7:0] ST_IDLE        = `FPE_ST_IDLE;
	localparam [7:0] ST_WRITE_PREP  = `FPE_ST_WRITE_PREP;
	localparam [7:0] ST_PROG        = `FPE_ST_PROG;
	localparam [7:0] ST_PROG_CHECK  = `FPE_ST_PROG_CHECK;
	localparam [7:0] ST_WIPE_PREP   = `FPE_ST_WIPE_PREP;
	localparam [7:0] ST_ERASE       = `FPE_ST_ERASE;
	localparam [7:0] ST_ERASE_CHECK = `FPE_ST_ERASE_CHECK;
	localparam [7:0] ST_FAULT       = `FPE_ST_FAULT;

	// Register state
	reg  [7:0]  serTimer_r;
	reg  [7:0]  serTimer_nxt;
	reg         swAllow_r;
	reg         swAllow_nxt;
	reg         eraseCheck_r_i;
	reg         eraseCheck_nxt;
	reg         progCheck_r_i;
	reg         progCheck_nxt;
	reg         erase_r;
	reg         erase_nxt;
	reg         prog_r;
	reg         prog_nxt;
	reg         wipePrep_r;
	reg         wipePrep_nxt;
	reg         writePrep_r;
	reg         writePrep_nxt;
	reg         fault_r;
	reg         fault_nxt;
	reg  [7:0]  eraseLo_r;
	reg  [7:0]  eraseLo_nxt;
	reg  [7:0]  eraseHi_r;
	reg  [7:0]  eraseHi_nxt;
	reg  [7:0]  state_nxt;
	reg  [31:0] prdata_nxt;
	reg         slvErr_r;
	reg         slvErr_nxt;

	wire [4:0]  modeCode;
	wire        normalMode;
	wire        progModeOk;
	wire        lowPowerClr;
	wire        gateOpen;
	wire        accessPhase;
	wire        setupPhase;
	wire        wrAny;
	wire        wrSerTimer;
	wire        wrModeCtrl;
	wire        wrSetupErr;
	wire        wrEraseLo;
	wire        wrEraseHi;
	wire [7:0]  wByte;
	wire [7:0]  modeCtrlView;
	wire [7:0]  setupErrView;

	// More than one set bit across both erase-select bytes
	function multiBits;
		input [15:0] v;
		begin
			multiBits = ((v & (v - 16'h0001)) != 16'h0000);
		end
	endfunction

	// Offset match for a flash register, closed while the gate is shut
	function flashHit;
		input [`FPE_ADDR_W-1:0] a;
		input                   gate;
		begin
			flashHit = gate & ((a == `FPE_OFF_MODE_CTRL) | (a == `FPE_OFF_SETUP_ERR)
				| (a == `FPE_OFF_ERASE_LO) | (a == `FPE_OFF_ERASE_HI));
		end
	endfunction

	fpe_mode_decode u_mode (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.mode_sel_hi  (mode_sel_hi),
		.mode_sel_lo  (mode_sel_lo),
		.boot_sel_2   (boot_sel_2),
		.boot_sel_1   (boot_sel_1),
		.boot_sel_0   (boot_sel_0),
		.modeCode_r   (modeCode),
		.bootMode     (bootMode),
		.userProgMode (userProgMode),
		.romEnable    (romEnable),
		.normalMode   (normalMode)
	);

	assign progModeOk  = bootMode | userProgMode;
	assign lowPowerClr = swStandby | subActive | subSleep | watchMode;
	assign gateOpen    = serTimer_r[`FPE_STC_GATE_BIT];

	// APB slave: zero wait states, byte lane 0 carries the data
	assign setupPhase  = psel & ~penable;
	assign accessPhase = psel & penable;
	assign pready      = 1'b1;
	assign pslverr     = accessPhase & slvErr_r;
	assign wrAny       = accessPhase & pwrite & pstrb[0] & ~slvErr_r;
	assign wByte       = pwdata[7:0];

	assign wrSerTimer = wrAny & (paddr == `FPE_OFF_SER_TIMER);
	assign wrModeCtrl = wrAny & gateOpen & (paddr == `FPE_OFF_MODE_CTRL);
	assign wrSetupErr = wrAny & gateOpen & (paddr == `FPE_OFF_SETUP_ERR);
	assign wrEraseLo  = wrAny & gateOpen & (paddr == `FPE_OFF_ERASE_LO);
	assign wrEraseHi  = wrAny & gateOpen & (paddr == `FPE_OFF_ERASE_HI);

	// Register views; bits 5 and 4 and the reserved field are wired low
	assign modeCtrlView = {1'b1, swAllow_r, 2'b00, eraseCheck_r_i, progCheck_r_i,
		erase_r, prog_r};
	assign setupErrView = {fault_r, 5'b00000, wipePrep_r, writePrep_r};

	// Next register values
	always @* begin
		serTimer_nxt   = serTimer_r;
		swAllow_nxt    = swAllow_r;
		eraseCheck_nxt = eraseCheck_r_i;
		progCheck_nxt  = progCheck_r_i;
		erase_nxt      = erase_r;
		prog_nxt       = prog_r;
		wipePrep_nxt   = wipePrep_r;
		writePrep_nxt  = writePrep_r;
		eraseLo_nxt    = eraseLo_r;
		eraseHi_nxt    = eraseHi_r;
		if (wrSerTimer) begin
			serTimer_nxt = wByte;
		end
		if (wrModeCtrl) begin
			swAllow_nxt = wByte[`FPE_MC_SW_ALLOW];
			if (!wByte[`FPE_MC_ERASE_CHECK]) begin
				eraseCheck_nxt = 1'b0;
			end else if (swAllow_r) begin
				eraseCheck_nxt = 1'b1;
			end
			if (!wByte[`FPE_MC_PROG_CHECK]) begin
				progCheck_nxt = 1'b0;
			end else if (swAllow_r) begin
				progCheck_nxt = 1'b1;
			end
			if (!wByte[`FPE_MC_ERASE]) begin
				erase_nxt = 1'b0;
			end else if (swAllow_r & wipePrep_r & ~fault_r) begin
				erase_nxt = 1'b1;
			end
			if (!wByte[`FPE_MC_PROG]) begin
				prog_nxt = 1'b0;
			end else if (swAllow_r & writePrep_r & ~fault_r) begin
				prog_nxt = 1'b1;
			end
		end
		if (wrSetupErr) begin
			if (!wByte[`FPE_SE_WIPE_PREP]) begin
				wipePrep_nxt = 1'b0;
			end else if (swAllow_r) begin
				wipePrep_nxt = 1'b1;
			end
			if (!wByte[`FPE_SE_WRITE_PREP]) begin
				writePrep_nxt = 1'b0;
			end else if (swAllow_r) begin
				writePrep_nxt = 1'b1;
			end
		end
		if (wrEraseLo && swAllow_r) begin
			eraseLo_nxt = wByte;
		end
		if (wrEraseHi && swAllow_r) begin
			eraseHi_nxt = wByte;
			if (normalMode) begin
				eraseHi_nxt[`FPE_EH_TOP_BLOCK] = eraseHi_r[`FPE_EH_TOP_BLOCK];
			end
		end
		if (multiBits({eraseHi_nxt, eraseLo_nxt})) begin
			eraseHi_nxt = `FPE_RST_ERASE;
			eraseLo_nxt = `FPE_RST_ERASE;
		end
		if (fault_r) begin
			erase_nxt = 1'b0;
			prog_nxt  = 1'b0;
		end
		if (!swAllow_nxt) begin
			wipePrep_nxt  = 1'b0;
			writePrep_nxt = 1'b0;
			eraseHi_nxt   = `FPE_RST_ERASE;
			eraseLo_nxt   = `FPE_RST_ERASE;
		end
		if (hwStandby || lowPowerClr) begin
			swAllow_nxt    = 1'b0;
			eraseCheck_nxt = 1'b0;
			progCheck_nxt  = 1'b0;
			erase_nxt      = 1'b0;
			prog_nxt       = 1'b0;
			wipePrep_nxt   = 1'b0;
			writePrep_nxt  = 1'b0;
			eraseHi_nxt    = `FPE_RST_ERASE;
			eraseLo_nxt    = `FPE_RST_ERASE;
		end
	end

	// Fault sets on any flash error; only reset and hardware standby clear it, and a set wins over hardware standby but not over reset
	always @* begin
		fault_nxt = flashErrEvt | (fault_r & ~hwStandby);
	end

	// Read data and error flag are prepared in the setup cycle
	always @* begin
		prdata_nxt = prdata;
		slvErr_nxt = slvErr_r;
		if (setupPhase) begin
			prdata_nxt = 32'h00000000;
			slvErr_nxt = 1'b0;
			if (paddr == `FPE_OFF_SER_TIMER) begin
				prdata_nxt[7:0] = serTimer_r;
			end else if (paddr == `FPE_OFF_STATUS) begin
				prdata_nxt[7:0]  = flashState_r;
				prdata_nxt[12:8] = modeCode;
				prdata_nxt[13]   = bootMode;
				prdata_nxt[14]   = userProgMode;
				prdata_nxt[15]   = romEnable;
			end else if (flashHit(paddr, gateOpen)) begin
				if (paddr == `FPE_OFF_MODE_CTRL) begin
					prdata_nxt[7:0] = modeCtrlView;
				end else if (paddr == `FPE_OFF_SETUP_ERR) begin
					prdata_nxt[7:0] = setupErrView;
				end else if (paddr == `FPE_OFF_ERASE_LO) begin
					prdata_nxt[7:0] = eraseLo_r;
				end else begin
					prdata_nxt[7:0] = eraseHi_r;
				end
			end else if (!flashHit(paddr, 1'b1)) begin
				slvErr_nxt = 1'b1;
			end
		end
	end

	// Flash state from the control bits, fault first
	always @* begin
		state_nxt = ST_IDLE;
		if (fault_r) begin
			state_nxt = ST_FAULT;
		end else if (!progModeOk) begin
			state_nxt = ST_IDLE;
		end else if (prog_r) begin
			state_nxt = ST_PROG;
		end else if (erase_r) begin
			state_nxt = ST_ERASE;
		end else if (progCheck_r_i) begin
			state_nxt = ST_PROG_CHECK;
		end else if (eraseCheck_r_i) begin
			state_nxt = ST_ERASE_CHECK;
		end else if (writePrep_r) begin
			state_nxt = ST_WRITE_PREP;
		end else if (wipePrep_r) begin
			state_nxt = ST_WIPE_PREP;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			serTimer_r     <= `FPE_RST_SER_TIMER;
			swAllow_r      <= 1'b0;
			eraseCheck_r_i <= 1'b0;
			progCheck_r_i  <= 1'b0;
			erase_r        <= 1'b0;
			prog_r         <= 1'b0;
			wipePrep_r     <= 1'b0;
			writePrep_r    <= 1'b0;
			fault_r        <= 1'b0;
			eraseLo_r      <= `FPE_RST_ERASE;
			eraseHi_r      <= `FPE_RST_ERASE;
			prdata         <= 32'h00000000;
			slvErr_r       <= 1'b0;
			flashState_r   <= ST_IDLE;
		end else begin
			serTimer_r     <= serTimer_nxt;
			swAllow_r      <= swAllow_nxt;
			eraseCheck_r_i <= eraseCheck_nxt;
			progCheck_r_i  <= progCheck_nxt;
			erase_r        <= erase_nxt;
			prog_r         <= prog_nxt;
			wipePrep_r     <= wipePrep_nxt;
			writePrep_r    <= writePrep_nxt;
			fault_r        <= fault_nxt;
			eraseLo_r      <= eraseLo_nxt;
			eraseHi_r      <= eraseHi_nxt;
			prdata         <= prdata_nxt;
			slvErr_r       <= slvErr_nxt;
			flashState_r   <= state_nxt;
		end
	end

	// Decoded controls toward the flash array
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			progRun_r      <= 1'b0;
			eraseRun_r     <= 1'b0;
			progCheck_r    <= 1'b0;
			eraseCheck_r   <= 1'b0;
			writePrepOn_r  <= 1'b0;
			wipePrepOn_r   <= 1'b0;
			errorProtect_r <= 1'b0;
			eraseSelect_r  <= 16'h0000;
		end else begin
			case (state_nxt)
				ST_PROG: begin
					progRun_r <= 1'b1;
				end
				default: begin
					progRun_r <= 1'b0;
				end
			endcase
			eraseRun_r     <= (state_nxt == ST_ERASE);
			progCheck_r    <= (state_nxt == ST_PROG_CHECK);
			eraseCheck_r   <= (state_nxt == ST_ERASE_CHECK);
			writePrepOn_r  <= (state_nxt == ST_WRITE_PREP);
			wipePrepOn_r   <= (state_nxt == ST_WIPE_PREP);
			errorProtect_r <= (state_nxt == ST_FAULT);
			eraseSelect_r  <= {eraseHi_r, eraseLo_r};
		end
	end

endmodule

/* verif/fpe_flash_checker.sv */
// Port-level assertions for the flash control block
`timescale 1ns/1ns
`include "fpe_flash_map.vh"
module fpe_flash_checker (
	input wire        sys_clk,
	input wire        reset_n,
	input wire [11:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pready,
	input wire        pslverr,
	input wire        hwStandby,
	input wire        swStandby,
	input wire        flashErrEvt,
	input wire [7:0]  flashState_r,
	input wire        progRun_r,
	input wire        eraseRun_r,
	input wire        writePrepOn_r,
	input wire        wipePrepOn_r,
	input wire        errorProtect_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_ready_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_err_map: assert property (psel && penable |-> pslverr == (paddr > `FPE_OFF_STATUS))
		else $error("pslverr does not match address map");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_state_onehot: assert property ($onehot(flashState_r))
		else $error("state not one-hot");
	a_prog_state: assert property (progRun_r |-> flashState_r == `FPE_ST_PROG)
		else $error("program output without program state");
	a_erase_state: assert property (eraseRun_r |-> flashState_r == `FPE_ST_ERASE)
		else $error("erase output without erase state");
	a_fault_blocks: assert property (errorProtect_r |-> !progRun_r && !eraseRun_r)
		else $error("program or erase during fault");
	a_fault_entry: assert property (flashErrEvt && !hwStandby |-> ##[1:2] errorProtect_r)
		else $error("fault not entered");
	a_standby_idle: assert property (hwStandby [*2] |-> ##1 flashState_r == `FPE_ST_IDLE)
		else $error("state not idle in hardware standby");
	a_low_power: assert property (swStandby [*2] |-> ##1
		!(progRun_r || eraseRun_r || writePrepOn_r || wipePrepOn_r))
		else $error("activity in software standby");
	c_prog: cover property (progRun_r);
	c_erase: cover property (eraseRun_r);
	c_fault: cover property (errorProtect_r);
endmodule

bind fpe_flash_ctrl fpe_flash_checker chk (.sys_clk, .reset_n, .paddr, .psel, .penable,
	.pready, .pslverr, .hwStandby, .swStandby, .flashErrEvt, .flashState_r, .progRun_r,
	.eraseRun_r, .writePrepOn_r, .wipePrepOn_r, .errorProtect_r);

/* verif/tb_fpe_flash_ctrl.sv */
// Self-checking bench for the flash control block
`timescale 1ns/1ns
`include "fpe_flash_map.vh"
module tb_fpe_flash_ctrl;
	logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic        hwStandby, flashErrEvt, progRun_r, eraseRun_r, errorProtect_r;
	logic        writePrepOn_r, wipePrepOn_r;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, lp;
	logic [7:0]  flashState_r, mc, se, stc;
	logic [15:0] eb;
	int          error_cnt, checks_done, i;

	fpe_flash_ctrl uut (.sys_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .hwStandby, .swStandby(lp[3]),
		.subActive(lp[2]), .subSleep(lp[1]), .watchMode(lp[0]), .flashErrEvt,
		.mode_sel_hi(1'b1), .mode_sel_lo(1'b0), .boot_sel_2(1'b0), .boot_sel_1(1'b0),
		.boot_sel_0(1'b0), .flashState_r, .progRun_r, .eraseRun_r, .progCheck_r(),
		.eraseCheck_r(), .writePrepOn_r, .wipePrepOn_r, .errorProtect_r,
		.eraseSelect_r(), .bootMode(), .userProgMode(), .romEnable());

	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	task test_done();
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function logic [7:0] st();
		if (se[7]) return `FPE_ST_FAULT;
		if (mc[0]) return `FPE_ST_PROG;
		if (mc[1]) return `FPE_ST_ERASE;
		if (mc[2]) return `FPE_ST_PROG_CHECK;
		if (mc[3]) return `FPE_ST_ERASE_CHECK;
		if (se[0]) return `FPE_ST_WRITE_PREP;
		if (se[1]) return `FPE_ST_WIPE_PREP;
		return `FPE_ST_IDLE;
	endfunction

	task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			error_cnt++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Register write plus the model's view of it
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, d);
		if (pstrb[0] && stc[3] && a == `FPE_OFF_MODE_CTRL) begin
			mc = {1'b1, d[6], 2'b00, d[3:2] & {2{mc[6]}}, d[1] & mc[6] & se[1] & !se[7],
				d[0] & mc[6] & se[0] & !se[7]};
			if (!mc[6]) begin
				se[1:0] = 2'b00;
				eb = 16'h0000;
			end
		end
		if (pstrb[0] && stc[3] && mc[6] && a == `FPE_OFF_ERASE_LO)
			eb[7:0] = d;
		if (pstrb[0] && stc[3] && mc[6] && a == `FPE_OFF_ERASE_HI)
			eb[15:8] = d;
		if ($countones(eb) > 1)
			eb = 16'h0000;
		if (pstrb[0] && stc[3] && a == `FPE_OFF_SETUP_ERR)
			se[1:0] = d[1:0] & {2{mc[6]}};
		if (pstrb[0] && a == `FPE_OFF_SER_TIMER)
			stc = d;
	endtask

	task chk_rd(input logic [11:0] a);
		logic [31:0] exp;
		apb(a, 1'b0, 8'h00);
		exp = 0;
		if (a == `FPE_OFF_SER_TIMER)
			exp = {24'h0, stc};
		if (stc[3] && a == `FPE_OFF_MODE_CTRL)
			exp = {24'h0, mc};
		if (stc[3] && a == `FPE_OFF_SETUP_ERR)
			exp = {24'h0, se};
		if (stc[3] && a == `FPE_OFF_ERASE_LO)
			exp = {24'h0, eb[7:0]};
		if (stc[3] && a == `FPE_OFF_ERASE_HI)
			exp = {24'h0, eb[15:8]};
		if (a == `FPE_OFF_STATUS)
			exp = {16'h0, 3'b110, 5'b10000, st()};
		cmp(rd, exp);
		cmp({31'h0, err}, {31'h0, a > `FPE_OFF_STATUS});
	endtask

	task chk_st();
		@(posedge sys_clk);
		#1;
		cmp({24'h0, flashState_r}, {24'h0, st()});
		cmp({31'h0, errorProtect_r}, {31'h0, se[7]});
	endtask

	initial begin
		#200000;
		error_cnt++;
		test_done();
	end

	initial begin
		i = $urandom(60418);
		{reset_n, psel, penable, pwrite, hwStandby, flashErrEvt} = 0;
		{paddr, pwdata, lp, mc, se, stc, eb, error_cnt, checks_done} = 0;
		pstrb = 4'hf;
		mc = 8'h80;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1;
		chk_rd(`FPE_OFF_MODE_CTRL);
		wr(`FPE_OFF_MODE_CTRL, 8'hff);
		wr(`FPE_OFF_SER_TIMER, 8'h08);
		chk_rd(`FPE_OFF_MODE_CTRL);
		chk_rd(`FPE_OFF_SETUP_ERR);
		wr(`FPE_OFF_MODE_CTRL, 8'hff);
		chk_rd(`FPE_OFF_MODE_CTRL);
		wr(`FPE_OFF_ERASE_LO, 8'h04);
		chk_rd(`FPE_OFF_ERASE_LO);
		wr(`FPE_OFF_ERASE_HI, 8'h01);
		chk_rd(`FPE_OFF_ERASE_HI);
		chk_rd(`FPE_OFF_ERASE_LO);
		wr(`FPE_OFF_SETUP_ERR, 8'h01);
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc2);
		chk_rd(`FPE_OFF_MODE_CTRL);
		wr(`FPE_OFF_MODE_CTRL, 8'hc1);
		chk_st();
		chk_rd(`FPE_OFF_STATUS);
		wr(`FPE_OFF_MODE_CTRL, 8'hc0);
		chk_st();
		wr(`FPE_OFF_SETUP_ERR, 8'h02);
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc2);
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc0);
		wr(`FPE_OFF_MODE_CTRL, 8'hc4);
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc8);
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc0);
		wr(`FPE_OFF_SETUP_ERR, 8'h03);
		wr(`FPE_OFF_MODE_CTRL, 8'h80);
		chk_rd(`FPE_OFF_SETUP_ERR);
		pstrb <= 4'h0;
		wr(`FPE_OFF_MODE_CTRL, 8'hc0);
		pstrb <= 4'hf;
		chk_rd(`FPE_OFF_MODE_CTRL);
		for (i = 0; i < 4; i++) begin
			wr(`FPE_OFF_MODE_CTRL, 8'hc0);
			wr(`FPE_OFF_SETUP_ERR, 8'h01);
			wr(`FPE_OFF_MODE_CTRL, 8'hc1);
			lp <= 4'b1000 >> i;
			repeat (3) @(posedge sys_clk);
			lp <= 4'h0;
			mc = 8'h80;
			se[1:0] = 2'b00;
			eb = 16'h0000;
			wr(`FPE_OFF_SER_TIMER, 8'h08);
			chk_rd(`FPE_OFF_MODE_CTRL);
			chk_rd(`FPE_OFF_SETUP_ERR);
			chk_st();
		end
		wr(`FPE_OFF_MODE_CTRL, 8'hc0);
		wr(`FPE_OFF_SETUP_ERR, 8'h01);
		wr(`FPE_OFF_MODE_CTRL, 8'hc1);
		flashErrEvt <= 1;
		@(posedge sys_clk);
		flashErrEvt <= 0;
		se[7] = 1'b1;
		mc[1:0] = 2'b00;
		chk_st();
		wr(`FPE_OFF_MODE_CTRL, 8'hc1);
		chk_rd(`FPE_OFF_MODE_CTRL);
		chk_rd(`FPE_OFF_SETUP_ERR);
		hwStandby <= 1;
		repeat (3) @(posedge sys_clk);
		hwStandby <= 0;
		mc = 8'h80;
		se = 8'h00;
		eb = 16'h0000;
		wr(`FPE_OFF_SER_TIMER, 8'h08);
		chk_rd(`FPE_OFF_SETUP_ERR);
		chk_st();
		repeat (6) begin
			wr(`FPE_OFF_SER_TIMER, 8'($urandom));
			chk_rd(`FPE_OFF_SER_TIMER);
			chk_rd(`FPE_OFF_MODE_CTRL);
		end
		chk_rd(12'h018);
		test_done();
	end
endmodule
